/* rtl/rsf_defs.svh */
// Constants for the radio sample frame generator
`ifndef RSF_DEFS_SVH
`define RSF_DEFS_SVH

// ****************************************
// Frame layout
// ****************************************
`define RSF_FRAME_ID      8'hB7
`define RSF_FRAME_BYTES   5082
`define RSF_PAIRS         1250
`define RSF_PAIR_LAST     11'h4E1
`define RSF_SUB_LAST      7'h7C
`define RSF_META_SLOTS    7'h08
`define RSF_RAD_BYTES     4'h5
`define RSF_STATUS_LSB    4
`define RSF_ACC_W         40
`define RSF_TAG_W         24

// ****************************************
// Timing
// ****************************************
`define RSF_CLK_NS        100
`define RSF_FRAME_NS      1024000000
`define RSF_LOAD_CYC      24'h000002

// ****************************************
// Test patterns
// ****************************************
`define RSF_IMPULSE_VAL   16'sh0080
`define RSF_IMPULSE_LEN   16'h0002
`define RSF_SQ_AMP        16'sh0100
`define RSF_SQ_LO_BIT     13
`define RSF_SQ_MID_BIT    8
`define RSF_SQ_HI_BIT     6
`define RSF_LFSR_SEED     16'hACE1

`endif

/* rtl/rsf_pkg.sv */
// Types for the radio sample frame generator
package rsf_pkg;
`include "rsf_defs.svh"

	typedef logic [2:0] rsf_sel_t;

	typedef enum logic [1:0] {RSF_OFF, RSF_ARMED, RSF_RUN} rsf_mode_t;

	typedef enum logic [2:0] {
		RSF_SRC_ADC, RSF_SRC_IMPULSE, RSF_SRC_SQ_LO, RSF_SRC_SQ_MID,
		RSF_SRC_PRN_ONE, RSF_SRC_PRN_FULL, RSF_SRC_SQ_HI, RSF_SRC_ZERO
	} rsf_src_t;

	typedef struct packed {
		rsf_mode_t           mode;
		logic                pps_m;
		logic                pps_s;
		logic                pps_d;
		rsf_sel_t            sel;
		logic [23:0]         timer;
		logic [10:0]         pair;
		logic [6:0]          sub_k;
		logic [15:0]         scnt;
		logic [15:0]         lfsr;
		logic signed [15:0]  smp_prev;
		logic [`RSF_ACC_W-1:0] acc;
		logic [`RSF_TAG_W-1:0] tag;
		logic [`RSF_ACC_W-1:0] rad_snap;
		logic [`RSF_TAG_W-1:0] tag_snap;
		logic [55:0]         q_bytes;
		logic [2:0]          q_cnt;
		logic                fs_pend;
		logic [7:0]          byte_out;
		logic                byte_vld;
		logic                fs_out;
	} rsf_state_t;
endpackage

/* rtl/rsf_frame_gen.sv */
// Radio sample frame generator: test source, radiometry, time tags, byte stream
`timescale 1ns/1ps
`include "rsf_defs.svh"

module rsf_frame_gen #(
	parameter int ADC_W     = 12,
	parameter int FRAME_CYC = `RSF_FRAME_NS / `RSF_CLK_NS
) (
	// Clock and reset
	input  wire logic                    i_ref_clk,
	input  wire logic                    i_rst_n,
	// Host commands and timing
	input  wire logic                    i_power_on,
	input  wire logic                    i_pps,
	input  wire rsf_pkg::rsf_sel_t       i_test_sel,
	// Converter
	input  wire logic signed [ADC_W-1:0] i_adc_sample,
	// Output frame stream
	output logic [7:0]                   o_byte,
	output logic                         o_byte_valid,
	output logic                         o_frame_start,
	output logic                         o_running
);
	import rsf_pkg::*;

	// One pair slot per PAIR_CYC cycles; must be at least 7 for the byte queue
	localparam int          PAIR_CYC  = FRAME_CYC / `RSF_PAIRS;
	localparam logic [23:0] PAIR_LAST = 24'(PAIR_CYC - 1);

	rsf_state_t         q;
	rsf_state_t         d;
	logic               pps_rise;
	logic               tick;
	logic               load;
	logic signed [15:0] adc16;
	logic signed [15:0] smp;
	logic [39:0]        sq;
	logic [39:0]        acc_sum;
	logic [7:0]         status;
	logic [7:0]         meta;
	logic [55:0]        qv;

	// ****************************************
	// Functions
	// ****************************************
	function automatic logic [39:0] square40(input logic signed [15:0] s);
		logic signed [31:0] w;
		w = 32'(s);
		return 40'($unsigned(w * w));
	endfunction

	function automatic logic signed [15:0] pick_sample(input rsf_sel_t sel,
			input logic [15:0] n, input logic [15:0] prn, input logic signed [15:0] adc);
		logic signed [15:0] r;
		r = 16'sh0000;
		case (rsf_src_t'(sel))
			RSF_SRC_ADC:      r = adc;
			RSF_SRC_IMPULSE:  r = (n < `RSF_IMPULSE_LEN) ? `RSF_IMPULSE_VAL : 16'sh0000;
			RSF_SRC_SQ_LO:    r = n[`RSF_SQ_LO_BIT] ? -`RSF_SQ_AMP : `RSF_SQ_AMP;
			RSF_SRC_SQ_MID:   r = n[`RSF_SQ_MID_BIT] ? -`RSF_SQ_AMP : `RSF_SQ_AMP;
			RSF_SRC_PRN_ONE:  r = prn[0] ? -16'sh0001 : 16'sh0001;
			RSF_SRC_PRN_FULL: r = $signed(prn);
			RSF_SRC_SQ_HI:    r = n[`RSF_SQ_HI_BIT] ? -`RSF_SQ_AMP : `RSF_SQ_AMP;
			RSF_SRC_ZERO:     r = 16'sh0000;
			default:          r = 16'sh0000;
		endcase
		return r;
	endfunction

	// Radiometry bytes first, then time tag, both MSB first
	function automatic logic [7:0] meta_byte(input logic [6:0] k,
			input logic [39:0] rad, input logic [23:0] tag);
		logic [39:0] rs;
		logic [23:0] ts;
		rs = rad >> (8 * (4 - k));
		ts = tag >> (8 * (7 - k));
		return (k < 7'(`RSF_RAD_BYTES)) ? rs[7:0] : ts[7:0];
	endfunction

	// ****************************************
	// Next state
	// ****************************************
	assign adc16    = 16'(i_adc_sample);
	assign pps_rise = q.pps_s & ~q.pps_d;
	assign tick     = (q.mode == RSF_RUN) && (q.timer == 24'h000000);
	assign load     = (q.mode == RSF_RUN) && (q.timer == `RSF_LOAD_CYC);
	assign smp      = pick_sample(q.sel, q.scnt, q.lfsr, adc16);
	assign sq       = square40(smp);
	assign acc_sum  = q.acc + sq;
	assign status   = {1'b0, q.sel, 4'h0};
	assign meta     = meta_byte(q.sub_k, q.rad_snap, q.tag_snap);

	always_comb begin
		d          = q;
		qv         = 56'h0;
		// Only the second stage reads the first; edge detect uses stages two and three
		d.pps_m    = i_pps;
		d.pps_s    = q.pps_m;
		d.pps_d    = q.pps_s;
		d.smp_prev = smp;
		d.byte_vld = 1'b0;
		d.fs_out   = 1'b0;
		d.lfsr     = {q.lfsr[14:0], q.lfsr[15] ^ q.lfsr[13] ^ q.lfsr[12] ^ q.lfsr[10]};
		if (q.q_cnt != 3'h0) begin
			d.byte_out = q.q_bytes[55:48];
			d.byte_vld = 1'b1;
			d.fs_out   = q.fs_pend;
			d.fs_pend  = 1'b0;
			d.q_bytes  = {q.q_bytes[47:0], 8'h00};
			d.q_cnt    = q.q_cnt - 3'h1;
		end
		case (q.mode)
			RSF_OFF: begin
				if (i_power_on) begin
					d.mode = RSF_ARMED;
				end
			end
			RSF_ARMED: begin
				if (pps_rise) begin
					d.mode  = RSF_RUN;
					d.timer = 24'h000000;
					d.pair  = 11'h000;
					d.sub_k = 7'h00;
					d.tag   = '0;
					d.acc   = '0;
					d.scnt  = 16'h0000;
					d.lfsr  = `RSF_LFSR_SEED;
					d.sel   = i_test_sel;
				end
			end
			RSF_RUN: begin
				// Wraps forever; only power-off leaves this state
				d.timer = (q.timer == PAIR_LAST) ? 24'h000000 : q.timer + 24'h000001;
				d.scnt  = q.scnt + 16'h0001;
				d.acc   = acc_sum;
				if (tick && q.pair == 11'h000) begin
					// Full previous-frame sum goes out as first value of the new frame
					d.rad_snap = acc_sum;
					d.acc      = '0;
					d.scnt     = 16'h0000;
					d.sel      = i_test_sel;
				end else if (tick && q.sub_k == 7'h00) begin
					d.rad_snap = acc_sum;
				end
				if (tick && q.sub_k == 7'h00) begin
					d.tag_snap = q.tag;
					d.tag      = q.tag + 24'h000001;
				end
				if (load) begin
					// I/Q taken two samples after the boundary, so the new source is in use
					qv = {`RSF_FRAME_ID, status, smp, q.smp_prev, meta};
					if (q.pair != 11'h000) begin
						qv = {qv[39:0], 16'h0000};
					end
					d.q_bytes = qv;
					d.q_cnt   = 3'h4 + ((q.sub_k < `RSF_META_SLOTS) ? 3'h1 : 3'h0)
						+ ((q.pair == 11'h000) ? 3'h2 : 3'h0);
					d.fs_pend = (q.pair == 11'h000);
					d.pair    = (q.pair == `RSF_PAIR_LAST) ? 11'h000 : q.pair + 11'h001;
					d.sub_k   = (q.sub_k == `RSF_SUB_LAST) ? 7'h00 : q.sub_k + 7'h01;
				end
			end
			default: d.mode = RSF_OFF;
		endcase
		if (!i_power_on) begin
			d.mode  = RSF_OFF;
			d.q_cnt = 3'h0;
		end
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign o_byte        = q.byte_out;
	assign o_byte_valid  = q.byte_vld;
	assign o_frame_start = q.fs_out;
	assign o_running     = (q.mode == RSF_RUN);

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);

	logic [31:0] gap_cnt;
	logic        gap_seen;
	logic [12:0] byte_cnt;
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			gap_cnt  <= 32'h0;
			gap_seen <= 1'b0;
			byte_cnt <= 13'h0;
		end else begin
			gap_cnt  <= o_frame_start ? 32'h1 : gap_cnt + 32'h1;
			gap_seen <= (o_frame_start | gap_seen) & o_running;
			byte_cnt <= o_frame_start ? 13'h1 : byte_cnt + 13'(o_byte_valid);
		end
	end

	property p_start_on_pps;
		(q.mode == RSF_ARMED) && pps_rise && i_power_on |=> o_running;
	endproperty
	a_start_on_pps: assert property (p_start_on_pps) else $error("no start at strobe");

	property p_no_early_start;
		(q.mode != RSF_RUN) && !pps_rise |=> !o_running;
	endproperty
	a_no_early_start: assert property (p_no_early_start) else $error("start without strobe");

	property p_frame_period;
		o_frame_start && gap_seen |-> gap_cnt == 32'(FRAME_CYC);
	endproperty
	a_frame_period: assert property (p_frame_period) else $error("frame period wrong");

	property p_keep_running;
		o_running && i_power_on |=> o_running;
	endproperty
	a_keep_running: assert property (p_keep_running) else $error("stream stopped");

	property p_frame_head;
		o_frame_start |-> o_byte == `RSF_FRAME_ID ##1 o_byte_valid && o_byte == status;
	endproperty
	a_frame_head: assert property (p_frame_head) else $error("frame head wrong");

	property p_status_bits;
		o_frame_start |=> o_byte[7] == 1'b0 && o_byte[3:0] == 4'h0;
	endproperty
	a_status_bits: assert property (p_status_bits) else $error("status reserved bits");

	property p_frame_bytes;
		o_frame_start && gap_seen |-> $past(byte_cnt) == 13'(`RSF_FRAME_BYTES);
	endproperty
	a_frame_bytes: assert property (p_frame_bytes) else $error("frame byte count");

	property p_tag_step;
		tick && q.sub_k == 7'h00 && i_power_on |=> q.tag == $past(q.tag) + 24'h000001;
	endproperty
	a_tag_step: assert property (p_tag_step) else $error("time tag step");

	property p_acc_clear;
		tick && q.pair == 11'h000 && i_power_on |=> q.acc == 40'h0 ##1 q.acc == $past(sq);
	endproperty
	a_acc_clear: assert property (p_acc_clear) else $error("accumulator not cleared");

	property p_sel_hold;
		o_running && !(tick && q.pair == 11'h000) |=> $stable(q.sel);
	endproperty
	a_sel_hold: assert property (p_sel_hold) else $error("selection moved mid-frame");

	c_start:   cover property ((q.mode == RSF_ARMED) ##1 o_running);
	c_frame:   cover property (o_frame_start && gap_seen);
	c_test:    cover property (o_frame_start ##1 o_byte[6:4] != 3'h0);
	c_tagmeta: cover property (load && q.sub_k == 7'h07);

endmodule // rsf_frame_gen

/* sim/rsf_host_model.sv */
// Host side model: power command, strobe, input select, frame capture
`timescale 1ns/1ps
module rsf_host_model (
	// Clock
	input  wire logic         i_ref_clk,
	// Frame stream from the device
	input  wire logic [7:0]   i_byte,
	input  wire logic         i_byte_valid,
	input  wire logic         i_frame_start,
	// Commands to the device
	output logic              o_power_on,
	output logic              o_pps,
	output rsf_pkg::rsf_sel_t o_test_sel
);
	import rsf_pkg::*;
	logic [7:0]  frm [0:5081];
	logic [31:0] cnt;
	logic [31:0] len;
	logic [31:0] gap;
	logic [31:0] period;
	initial begin
		o_power_on = 1'b0;
		o_pps = 1'b0;
		o_test_sel = 3'h7;
		cnt = 0;
		len = 0;
		gap = 0;
		period = 0;
	end
	task automatic power(input logic v);
		@(posedge i_ref_clk) o_power_on <= v;
	endtask
	// Held three edges: the synchroniser needs only one
	task automatic strobe();
		@(posedge i_ref_clk) o_pps <= 1'b1;
		repeat (3) @(posedge i_ref_clk);
		o_pps <= 1'b0;
	endtask
	task automatic select(input rsf_sel_t s);
		@(posedge i_ref_clk) o_test_sel <= s;
	endtask
	always @(posedge i_ref_clk) begin
		gap <= i_frame_start ? 1 : gap + 1;
		if (i_frame_start) begin
			period <= gap;
			len <= cnt;
		end
		if (i_byte_valid) begin
			cnt <= i_frame_start ? 1 : cnt + 1;
			if (i_frame_start)
				frm[0] <= i_byte;
			else if (cnt < 5082)
				frm[cnt] <= i_byte;
		end
	end
endmodule // rsf_host_model

/* sim/rsf_frame_gen_tb_top.sv */
// Self-checking bench for the radio sample frame generator
`timescale 1ns/1ps
module rsf_frame_gen_tb_top;
	import rsf_pkg::*;
	logic               clk;
	logic               rst_n;
	logic               pw;
	logic               pps;
	rsf_sel_t           sel;
	logic signed [11:0] adc;
	logic [7:0]         byt;
	logic               vld;
	logic               fs;
	logic               run;
	int                 miscompares;
	int                 total_checks;
	rsf_frame_gen #(.ADC_W(12), .FRAME_CYC(12500)) u_rsf_frame_gen (.i_ref_clk(clk),
		.i_rst_n(rst_n), .i_power_on(pw), .i_pps(pps), .i_test_sel(sel),
		.i_adc_sample(adc), .o_byte(byt), .o_byte_valid(vld), .o_frame_start(fs),
		.o_running(run));
	rsf_host_model u_rsf_host_model (.i_ref_clk(clk), .i_byte(byt), .i_byte_valid(vld),
		.i_frame_start(fs), .o_power_on(pw), .o_pps(pps), .o_test_sel(sel));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic check(input logic [39:0] got, input logic [39:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// ****
	// Frame field access and expected power sums
	// ****
	function automatic logic [39:0] fld(input int j, input int k, input int n);
		logic [39:0] v;
		v = '0;
		for (int b = 0; b < n; b++)
			v = {v[31:0], u_rsf_host_model.frm[2 + 508 * j + 5 * (k + b) + 4]};
		return v;
	endfunction
	// Every square wave sample squares to 65536, whatever its phase
	function automatic logic [39:0] full(input rsf_sel_t s);
		case (s)
			3'h0: return 40'd3200000;
			3'h1: return 40'd32768;
			3'h4: return 40'd12500;
			3'h7: return 40'd0;
			default: return 40'd819200000;
		endcase
	endfunction
	task automatic wait_start();
		int i;
		i = 0;
		do begin
			@(negedge clk);
			i++;
		end while (fs !== 1'b1 && i < 13000);
		check(fs, 1'b1);
		check(byt, 8'hB7);
		// Host logs the start one edge later; its counters lag until then
		@(negedge clk);
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// ****
	// Scenarios
	// ****
	task automatic t_start();
		u_rsf_host_model.power(1'b1);
		repeat (20) @(posedge clk);
		@(negedge clk);
		check(run, 1'b0);
		u_rsf_host_model.strobe();
		wait_start();
		check(run, 1'b1);
		$display("test start done");
	endtask
	task automatic t_frames();
		rsf_sel_t s [0:9] = '{3'h7, 3'h7, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h0, 3'h0};
		for (int m = 0; m < 8; m++) begin
			repeat (100) @(posedge clk);
			u_rsf_host_model.select(s[m + 2]);
			wait_start();
			check(u_rsf_host_model.period, 12500);
			check(u_rsf_host_model.len, 5082);
			check(u_rsf_host_model.frm[1], {1'b0, s[m + 1], 4'h0});
			check(fld(0, 5, 3), 10 * m);
			check(fld(9, 5, 3), 10 * m + 9);
			if (s[m + 1] != 3'h5)
				check(fld(1, 0, 5), s[m + 1] == 3'h1 ? 40'd32768 : full(s[m + 1]) / 10);
			if (s[m] != 3'h5)
				check(fld(0, 0, 5), full(s[m]));
			if (s[m + 1] == 3'h0) begin
				check({u_rsf_host_model.frm[2], u_rsf_host_model.frm[3]}, 16'h0010);
				check({u_rsf_host_model.frm[4], u_rsf_host_model.frm[5]}, 16'h0010);
			end
		end
		$display("test frames done");
	endtask
	task automatic t_power_off();
		int c;
		u_rsf_host_model.power(1'b0);
		repeat (3) @(posedge clk);
		@(negedge clk);
		check(run, 1'b0);
		c = u_rsf_host_model.cnt;
		repeat (200) @(posedge clk);
		@(negedge clk);
		check(u_rsf_host_model.cnt, c);
		u_rsf_host_model.power(1'b1);
		repeat (50) @(posedge clk);
		@(negedge clk);
		check(run, 1'b0);
		$display("test power off done");
	endtask
	// Eight frames of 12500 cycles, start-up and power-off, plus a small margin
	initial begin
		#10200000;
		miscompares++;
		print_verdict();
	end
	initial begin
		miscompares = 0;
		total_checks = 0;
		rst_n = 1'b0;
		adc = 12'sh010;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		t_start();
		t_frames();
		t_power_off();
		print_verdict();
	end
endmodule // rsf_frame_gen_tb_top
